/* File: dac_chain_map.vh */
`ifndef DAC_CHAIN_MAP_VH
`define DAC_CHAIN_MAP_VH

// ****************************************************************
// Serial word layout.
// ****************************************************************
`define DAC_SHIFT_WIDTH 16
`define DAC_CODE_WIDTH 10
`define DAC_CODE_MSB 11
`define DAC_CODE_LSB 2
`define DAC_SHORT_FRAME_BITS 5'h0C
`define DAC_BIT_COUNT_MAX 5'h1F

// ****************************************************************
// Reset values.
// ****************************************************************
`define DAC_CODE_RESET 10'h000
`define DAC_SHIFT_RESET 16'h0000

// ****************************************************************
// Code buffer shape.
// ****************************************************************
`define DAC_FIFO_DEPTH 16
`define DAC_FIFO_ADDR_W 4

`endif

/* File: dac_code_fifo.v */
`timescale 1ns/10ps
`default_nettype none

module dac_code_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter ADDR_W = 4
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr_reg;
  reg [ADDR_W-1:0] rd_ptr_reg;
  reg [ADDR_W:0] count_reg;
  wire push;
  wire pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_out = (count_reg != DEPTH[ADDR_W:0]);
  assign out_valid_out = (count_reg != {(ADDR_W+1){1'b0}});
  assign out_data_out = mem[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= {ADDR_W{1'b0}};
      rd_ptr_reg <= {ADDR_W{1'b0}};
      count_reg <= {(ADDR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} :
                      wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[ADDR_W-1:0] - 1'b1) ? {ADDR_W{1'b0}} :
                      rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: dac_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ***
// Serial host with a 64 ns link clock that idles low.
// ***
module dac_host_model (
  output logic sel_n_out,
  output logic lclk_out,
  output logic serial_out,
  input wire logic chain_in
);
  logic [15:0] seen = 16'h0000;
  initial begin
    sel_n_out = 1'b1;
    lclk_out = 1'b0;
    serial_out = 1'b0;
  end
  // Sends the low n bits MSB first, keeping the chain bit seen before each rise.
  task automatic frame(input logic [15:0] w, input int n);
    sel_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_out = w[i];
      #32 seen = {seen[14:0], chain_in};
      lclk_out = 1'b1;
      #32 lclk_out = 1'b0;
    end
    #32 sel_n_out = 1'b1;
    serial_out = ~serial_out;
    #64;
  endtask
  // Raises select while the link clock is high, on purpose, to provoke the timing flag.
  task automatic glitch();
    sel_n_out = 1'b0;
    #32 lclk_out = 1'b1;
    #32 sel_n_out = 1'b1;
    #32 lclk_out = 1'b0;
    #64;
  endtask
  // Moves clock and data while deselected, on purpose.
  task automatic stray();
    repeat (4) begin
      #32 lclk_out = 1'b1;
      serial_out = ~serial_out;
      #32 lclk_out = 1'b0;
    end
    #32;
  endtask
endmodule
`default_nettype wire

/* File: dac_serial_load_chain.v */
// Overview of operation
// R1 - Power-on reset clears the converter code register to all zeros.
// R2 - With select low, bits enter a 16-bit shift register, MSB first.
// R3 - Each shift clock rising edge shifts in the current serial input bit.
// R4 - Select rising edge copies the data bits into the converter code register; this design queues them in a 16-entry buffer until UPDATE_READY_IN is high.
// R5 - With select high, clock edges leave the shift register untouched.
// R6 - Host changes select only while the shift clock is low.
// R7 - Unchained host may send a short 12-bit frame, MSB first.
// R8 - Host may instead send 16 bits with four leading dummy bits.
// R9 - Meaningful bits are the 10-bit code then two zero sub-LSB bits.
// R10 - Code is straight unsigned binary; output is twice reference times code/1024.
// R11 - With select low, chain output changes only on shift clock falling edges.
// R12 - With select high, chain output holds its last bit and stays driven.
// R13 - Serial input reaches chain output after sixteen clocks plus half a clock.
// R14 - Chained hosts send 16-bit frames; one extra falling edge pushes data out.
// R15 - Byte hosts write two bytes per select period; others write once.
// R16 - Host limits full-scale code updates to about 80 kHz.
// R17 - Host keeps the shift clock low whenever select is high.
// R18 - Code is taken from bits 11 to 2; the two sub-LSB bits are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "dac_chain_map.vh"

module dac_serial_load_chain #(
  parameter SHIFT_WIDTH = `DAC_SHIFT_WIDTH,
  parameter CODE_WIDTH = `DAC_CODE_WIDTH,
  parameter FIFO_DEPTH = `DAC_FIFO_DEPTH,
  parameter FIFO_ADDR_W = `DAC_FIFO_ADDR_W
) (
  input wire REF_CLK_IN,
  input wire RST_B_IN,
  input wire SELECT_N_IN,
  input wire SHIFT_CLOCK_IN,
  input wire SERIAL_IN_IN,
  input wire UPDATE_READY_IN,
  output wire CHAIN_OUT_OUT,
  output wire [CODE_WIDTH-1:0] DAC_CODE_OUT,
  output wire CODE_UPDATE_OUT,
  output wire BUFFER_READY_OUT,
  output wire OVERRUN_OUT,
  output wire SHORT_FRAME_OUT,
  output wire TIMING_FAULT_OUT,
  output wire [4:0] FRAME_BITS_OUT
);

  // ****************************************************************
  // Functions.
  // ****************************************************************
  function rise;
    input cur;
    input prev;
    begin
      rise = cur & ~prev;
    end
  endfunction

  function fall;
    input cur;
    input prev;
    begin
      fall = ~cur & prev;
    end
  endfunction

  // ****************************************************************
  // States.
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_COMMIT = 3'h4;

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  reg sel_sync1_reg;
  reg sel_sync2_reg;
  reg sel_prev_reg;
  reg sck_sync1_reg;
  reg sck_sync2_reg;
  reg sck_prev_reg;
  reg din_sync1_reg;
  reg din_sync2_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [SHIFT_WIDTH-1:0] shift_reg;
  reg [SHIFT_WIDTH-1:0] shift_next;
  reg chain_reg;
  reg chain_next;
  reg [4:0] bit_count_reg;
  reg [4:0] bit_count_next;
  reg [CODE_WIDTH-1:0] code_reg;
  reg update_reg;
  reg overrun_reg;
  reg short_frame_reg;
  reg timing_fault_reg;
  wire sel_rise;
  wire sel_fall;
  wire sck_rise;
  wire sck_fall;
  wire push_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [CODE_WIDTH-1:0] fifo_out_data;
  wire [CODE_WIDTH-1:0] frame_code;
  wire code_load;

  // ****************************************************************
  // Input synchronisers and edge detection.
  // ****************************************************************
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sel_sync1_reg <= 1'b1;
      sel_sync2_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
      sck_sync1_reg <= 1'b0;
      sck_sync2_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      din_sync1_reg <= 1'b0;
      din_sync2_reg <= 1'b0;
    end else begin
      sel_sync1_reg <= SELECT_N_IN;
      sel_sync2_reg <= sel_sync1_reg;
      sel_prev_reg <= sel_sync2_reg;
      sck_sync1_reg <= SHIFT_CLOCK_IN;
      sck_sync2_reg <= sck_sync1_reg;
      sck_prev_reg <= sck_sync2_reg;
      din_sync1_reg <= SERIAL_IN_IN;
      din_sync2_reg <= din_sync1_reg;
    end
  end

  assign sel_rise = rise(sel_sync2_reg, sel_prev_reg);
  assign sel_fall = fall(sel_sync2_reg, sel_prev_reg);
  assign sck_rise = rise(sck_sync2_reg, sck_prev_reg);
  assign sck_fall = fall(sck_sync2_reg, sck_prev_reg);

  // ****************************************************************
  // Frame state machine, shift register and chain output.
  // ****************************************************************
  always @* begin
    state_next = state_reg;
    shift_next = shift_reg;
    chain_next = chain_reg;
    bit_count_next = bit_count_reg;
    case (state_reg)
      ST_IDLE: begin
        // Clock edges are ignored here, so the shift register holds. R5
        if (sel_fall) begin
          state_next = ST_SHIFT;
          bit_count_next = 5'h00;
        end
      end
      ST_SHIFT: begin
        if (sel_rise) begin
          state_next = ST_COMMIT; // R4
        end else begin
          if (sck_rise) begin
            // New bits enter at the bottom, so after sixteen clocks the first bit is on top. R2 R3
            shift_next = {shift_reg[SHIFT_WIDTH-2:0], din_sync2_reg};
            if (bit_count_reg != `DAC_BIT_COUNT_MAX) begin
              bit_count_next = bit_count_reg + 5'h01;
            end
          end
          if (sck_fall) begin
            // The bit leaving the top is shown half a clock after it arrives there. R11 R13 R14
            chain_next = shift_reg[SHIFT_WIDTH-1];
          end
        end
      end
      ST_COMMIT: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_reg <= ST_IDLE;
      shift_reg <= `DAC_SHIFT_RESET;
      chain_reg <= 1'b0;
      bit_count_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next; // R5
      chain_reg <= chain_next; // R12
      bit_count_reg <= bit_count_next;
    end
  end

  // ****************************************************************
  // Code extraction and buffering.
  // ****************************************************************
  // The latch is the low twelve positions; the two sub-LSB bits are dropped. R18 R9
  assign frame_code = shift_reg[`DAC_CODE_MSB:`DAC_CODE_LSB];
  assign push_valid = (state_reg == ST_COMMIT);

  dac_code_fifo #(
    .WIDTH(CODE_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .ADDR_W(FIFO_ADDR_W)
  ) i_dac_code_fifo (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .in_valid_in(push_valid),
    .in_ready_out(fifo_in_ready),
    .in_data_in(frame_code),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(UPDATE_READY_IN),
    .out_data_out(fifo_out_data)
  );

  assign code_load = fifo_out_valid & UPDATE_READY_IN;

  // ****************************************************************
  // Converter code register and frame status.
  // ****************************************************************
  always @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      code_reg <= `DAC_CODE_RESET; // R1
      update_reg <= 1'b0;
      overrun_reg <= 1'b0;
      short_frame_reg <= 1'b0;
      timing_fault_reg <= 1'b0;
    end else begin
      update_reg <= code_load;
      if (code_load) begin
        // Stored as plain unsigned binary for the resistor string. R10 R4
        code_reg <= fifo_out_data;
      end
      // A frame lost to a full buffer stays flagged until the next frame starts.
      if (push_valid && !fifo_in_ready) begin
        overrun_reg <= 1'b1;
      end else if (sel_fall) begin
        overrun_reg <= 1'b0;
      end
      // Fewer than twelve clocks leave stale bits in the code positions. R7 R8 R15
      if (push_valid) begin
        short_frame_reg <= (bit_count_reg < `DAC_SHORT_FRAME_BITS);
      end
      // Select moving while the shift clock is high is flagged until the next frame. R6 R17
      if ((sel_rise || sel_fall) && sck_sync2_reg) begin
        timing_fault_reg <= 1'b1;
      end else if (sel_fall) begin
        timing_fault_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign CHAIN_OUT_OUT = chain_reg;
  assign DAC_CODE_OUT = code_reg;
  assign CODE_UPDATE_OUT = update_reg;
  assign BUFFER_READY_OUT = fifo_in_ready;
  assign OVERRUN_OUT = overrun_reg;
  assign SHORT_FRAME_OUT = short_frame_reg;
  assign TIMING_FAULT_OUT = timing_fault_reg;
  assign FRAME_BITS_OUT = bit_count_reg;

endmodule

`default_nettype wire

/* File: dac_serial_load_chain_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ***
// Port checks for the serial load chain.
// ***
module dac_serial_load_chain_sva #(
  parameter int CODE_WIDTH = 10
) (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic SELECT_N_IN,
  input wire logic SHIFT_CLOCK_IN,
  input wire logic UPDATE_READY_IN,
  input wire logic CHAIN_OUT_OUT,
  input wire logic [CODE_WIDTH-1:0] DAC_CODE_OUT,
  input wire logic CODE_UPDATE_OUT,
  input wire logic BUFFER_READY_OUT,
  input wire logic OVERRUN_OUT
);
  default clocking dcb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  // Registers are unknown until the first edge under reset, so that edge is skipped.
  logic armed = 1'b0;
  always @(posedge REF_CLK_IN) armed <= 1'b1;
  property p_rst;
    disable iff (1'b0) armed && !RST_B_IN |-> DAC_CODE_OUT == '0 && !CHAIN_OUT_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_rel;
    $rose(RST_B_IN) |-> DAC_CODE_OUT == '0 && BUFFER_READY_OUT;
  endproperty
  a_rel: assert property (p_rel) else $error("release value");
  property p_chg;
    $changed(DAC_CODE_OUT) |-> CODE_UPDATE_OUT;
  endproperty
  a_chg: assert property (p_chg) else $error("silent code change");
  property p_rdy;
    CODE_UPDATE_OUT |-> $past(UPDATE_READY_IN);
  endproperty
  a_rdy: assert property (p_rdy) else $error("load while stalled");
  property p_load;
    $rose(SELECT_N_IN) && UPDATE_READY_IN |-> ##[2:8] CODE_UPDATE_OUT;
  endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_hold;
    SELECT_N_IN [*6] |-> $stable(CHAIN_OUT_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("chain moved");
  property p_fall;
    $changed(CHAIN_OUT_OUT) |-> !SELECT_N_IN && !SHIFT_CLOCK_IN && $past(SHIFT_CLOCK_IN, 6);
  endproperty
  a_fall: assert property (p_fall) else $error("chain off fall");
  property p_ovr;
    $rose(OVERRUN_OUT) |-> !$past(BUFFER_READY_OUT);
  endproperty
  a_ovr: assert property (p_ovr) else $error("false overrun");
  c_load: cover property ($rose(CODE_UPDATE_OUT));
  c_ovr: cover property ($rose(OVERRUN_OUT));
  c_chain: cover property ($changed(CHAIN_OUT_OUT));
endmodule
bind dac_serial_load_chain dac_serial_load_chain_sva #(.CODE_WIDTH(CODE_WIDTH)) i_sva (.*);
`default_nettype wire

/* File: tb_dac_serial_load_chain.sv */
`timescale 1ns/10ps
`default_nettype none
// ***
// Bench for the serial load chain.
// ***
module tb_dac_serial_load_chain;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic upd_rdy = 1'b1;
  wire logic sel_n, lclk, sdi, chain, upd, buf_rdy, ovr;
  wire logic [9:0] code;
  wire logic short_frame, tfault;
  wire logic [4:0] bits;
  int n_fail = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  dac_serial_load_chain i_dac_serial_load_chain (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .SELECT_N_IN(sel_n), .SHIFT_CLOCK_IN(lclk),
    .SERIAL_IN_IN(sdi), .UPDATE_READY_IN(upd_rdy), .CHAIN_OUT_OUT(chain), .DAC_CODE_OUT(code),
    .CODE_UPDATE_OUT(upd), .BUFFER_READY_OUT(buf_rdy), .OVERRUN_OUT(ovr),
    .SHORT_FRAME_OUT(short_frame), .TIMING_FAULT_OUT(tfault), .FRAME_BITS_OUT(bits));
  dac_host_model host (
    .sel_n_out(sel_n), .lclk_out(lclk), .serial_out(sdi), .chain_in(chain));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_codes();
    logic [9:0] tab [6] = '{10'h3FF, 10'h200, 10'h201, 10'h1FF, 10'h001, 10'h000};
    for (int i = 0; i < 6; i++) begin
      host.frame({4'hA, tab[i], 2'(i)}, i[0] ? 12 : 16);
      check(16'(code), 16'(tab[i]));
      check(16'(bits), i[0] ? 16'h000C : 16'h0010);
      check(16'(short_frame), 16'h0000);
      if (i == 0) #12500;
    end
  endtask
  task automatic t_faults();
    @(posedge clk) #1;
    host.frame(16'h00FF, 8);
    check(16'(code), 16'h013F);
    check(16'(bits), 16'h0008);
    check(16'(short_frame), 16'h0001);
    check(16'(ovr), 16'h0000);
    check(16'(tfault), 16'h0000);
    host.glitch();
    check(16'(tfault), 16'h0001);
  endtask
  task automatic t_chain();
    host.frame(16'h5B0C, 16);
    host.stray();
    check(16'(code), 16'h02C3);
    host.frame(16'hC3A5, 16);
    check(host.seen, 16'h5B0C);
    check(16'(code), 16'h00E9);
    host.stray();
    check(16'(chain), 16'h0001);
  endtask
  task automatic t_fifo();
    int n;
    upd_rdy = 1'b0;
    for (int i = 1; i <= 17; i++) begin
      check(16'(buf_rdy), 16'(i <= 16));
      host.frame({4'h0, 10'(i), 2'b00}, 12);
    end
    check(16'(ovr), 16'h0001);
    @(posedge clk) #1 upd_rdy = 1'b1;
    n = 1;
    repeat (80) begin
      @(negedge clk);
      if (upd === 1'b1) begin
        check(16'(code), 16'(n));
        n++;
      end
    end
    check(16'(n), 16'h0011);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #1 check(16'({code, chain, buf_rdy, upd}), 16'h0002);
    t_codes();
    t_chain();
    t_fifo();
    t_faults();
    conclude();
  end
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
